// ---- hw/mccs_pkg.sv ----
/*
  constants shared by the machine cycle clock scaler: register offsets,
  field positions, reset values and cycle counts.
  assumes a single 250 MHz clock where one enabled edge is one oscillator clock.
*/
// Summary of operation
// R1 - twelve oscillator clocks per machine cycle by default
// R2 - double speed gives six clocks per cycle
// R3 - double speed only from host or command
// R4 - status bit shows six clock operation
// R5 - double speed only while external access high
// R6 - oscillator output never doubled
// R7 - divider offers 1/4, 1/16, 1/256, 1/1024
// R8 - division only while divider enable bit set
// R9 - select field chooses the division ratio
// R10 - ascending code order, changes at clean edge
// R11 - divider resets to undivided setting
package mccs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CLOCK_OPTION   = 4'h0; // clock_option_register
  localparam logic [3:0] ADDR_FLASH_STATUS   = 4'h4; // flash_status_register
  localparam logic [3:0] ADDR_IAP_COMMAND    = 4'h8; // in_application_programming command

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int        DIV_ENABLE_POS      = 0;    // divider_enable_bit
  localparam int        DIV_SELECT_LSB      = 1;    // divide_ratio_select, 2 bits
  localparam int        STATUS_DOUBLE_POS   = 7;    // six clock mode indication
  localparam int        STATUS_EXT_POS      = 0;    // synchronised external access level

  // ----------------------------------------------------------------
  // reset values and command codes
  // ----------------------------------------------------------------
  localparam logic       RESET_DIV_ENABLE    = 1'b0;
  localparam logic [1:0] RESET_DIV_SELECT    = 2'h0;
  localparam logic [7:0] IAP_CLOCK_DOUBLE    = 8'h0d; // command code, value arbitrary

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CLOCKS_PER_CYCLE_X1 = 4'hc; // twelve
  localparam logic [3:0] CLOCKS_PER_CYCLE_X2 = 4'h6; // six
  localparam logic [9:0] DIV_RATIO_4         = 10'h003; // ratio minus one
  localparam logic [9:0] DIV_RATIO_16        = 10'h00f;
  localparam logic [9:0] DIV_RATIO_256       = 10'h0ff;
  localparam logic [9:0] DIV_RATIO_1024      = 10'h3ff;

  // axi responses
  localparam logic [1:0] RESP_OKAY           = 2'h0;
  localparam logic [1:0] RESP_SLVERR         = 2'h2;

endpackage : mccs_pkg

// ---- hw/mccs_top.sv ----
/*
  machine cycle clock scaler: oscillator clock to system clock divider,
  machine cycle sequencer with a double speed option and an axi4-lite
  register slave.
  assumes clk_sys_i is the oscillator clock, host pins are asynchronous,
  and a master that keeps to the axi4-lite handshake.
*/
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
module mccs_top (
  // clock, reset and freeze
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        clk_en_i,
  // pins from outside the clock domain
  input  wire logic        host_double_speed_i,
  input  wire logic        external_access_pin_i,
  // clock products
  output logic             osc_output_pin_o,
  output logic             sys_clk_tick_o,
  output logic             machine_cycle_o,
  output logic             double_speed_o,
  // axi4-lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        aw_full;   // write address held
    logic [3:0]  aw_addr;
    logic        w_full;    // write data held
    logic [7:0]  w_data;    // only the low byte is ever used
    logic        w_lane;    // low byte lane strobe
    logic        b_valid;
    logic [1:0]  b_resp;
    logic        r_valid;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
    logic        div_en;    // software copy of divider enable
    logic [1:0]  div_sel;   // software copy of ratio select
    logic        act_en;    // setting in force
    logic [1:0]  act_sel;
    logic        iap_dbl;   // double speed requested by command
    logic        host_dbl;  // double speed requested by host
    logic [1:0]  host_sync; // synchroniser, bit 0 is the first stage
    logic [1:0]  ea_sync;
    logic        dbl_act;   // double speed in force
    logic [9:0]  pre_cnt;   // oscillator clocks within a system clock
    logic [3:0]  mc_cnt;    // system clocks within a machine cycle
    logic        sys_tick;
    logic        mc_tick;
    logic        osc_out;
  } mccs_state_type;

  mccs_state_type state;      // registered state
  mccs_state_type next_state; // value for the next edge

  // ratio minus one for a select code, ascending order
  function automatic logic [9:0] mccs_ratio(input logic [1:0] sel);
    case (sel)
      2'h0:    mccs_ratio = mccs_pkg::DIV_RATIO_4;
      2'h1:    mccs_ratio = mccs_pkg::DIV_RATIO_16;
      2'h2:    mccs_ratio = mccs_pkg::DIV_RATIO_256;
      default: mccs_ratio = mccs_pkg::DIV_RATIO_1024;
    endcase
  endfunction : mccs_ratio

  // ----------------------------------------------------------------
  // handshakes, combinational
  // ----------------------------------------------------------------
  // hold off new writes until the response has gone, one write at a time;
  // a frozen edge stores nothing, so ready stays low while the enable is low
  assign s_axi_awready = clk_en_i && !state.aw_full && !state.b_valid;
  assign s_axi_wready  = clk_en_i && !state.w_full && !state.b_valid;
  assign s_axi_arready = clk_en_i && !state.r_valid;

  // ----------------------------------------------------------------
  // outputs from flip-flops
  // ----------------------------------------------------------------
  assign s_axi_bvalid     = state.b_valid;
  assign s_axi_bresp      = state.b_resp;
  assign s_axi_rvalid     = state.r_valid;
  assign s_axi_rdata      = state.r_data;
  assign s_axi_rresp      = state.r_resp;
  assign osc_output_pin_o = state.osc_out;
  assign sys_clk_tick_o   = state.sys_tick;
  assign machine_cycle_o  = state.mc_tick;
  assign double_speed_o   = state.dbl_act;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        tick;     // one system clock passes this oscillator clock
    logic [3:0]  last_mc;  // final count of a machine cycle
    logic [31:0] rd;
    next_state = state;
    tick       = 1'b0;
    last_mc    = 4'h0;
    rd         = 32'h0000_0000;

    // synchronisers, first stage feeds only the second
    next_state.host_sync = {state.host_sync[0], host_double_speed_i};
    next_state.ea_sync   = {state.ea_sync[0], external_access_pin_i};

    // oscillator output toggles every clock whatever the mode
    next_state.osc_out = !state.osc_out; // [R6]

    // host request is sticky until reset, only path besides the command
    if (state.host_sync[1]) begin
      next_state.host_dbl = 1'b1; // [R3]
    end

    // system clock divider, bypassed while disabled
    if (!state.act_en) begin
      tick = 1'b1; // [R8]
      next_state.pre_cnt = 10'h000;
    end else if (state.pre_cnt >= mccs_ratio(state.act_sel)) begin
      tick = 1'b1; // [R7] [R9]
      next_state.pre_cnt = 10'h000;
    end else begin
      next_state.pre_cnt = state.pre_cnt + 10'h001;
    end
    // a new setting is taken only at a system clock boundary, no short pulse
    if (tick) begin
      next_state.act_en  = state.div_en;  // [R10]
      next_state.act_sel = state.div_sel; // [R10]
    end
    next_state.sys_tick = tick;

    // machine cycle sequencer
    last_mc = state.dbl_act ? mccs_pkg::CLOCKS_PER_CYCLE_X2 - 4'h1    // [R2]
                            : mccs_pkg::CLOCKS_PER_CYCLE_X1 - 4'h1;   // [R1]
    next_state.mc_tick = 1'b0;
    if (tick) begin
      if (state.mc_cnt >= last_mc) begin
        next_state.mc_cnt  = 4'h0;
        next_state.mc_tick = 1'b1;
        // mode changes only between machine cycles; external fetches stay x1
        next_state.dbl_act = (state.iap_dbl || state.host_dbl)
                             && state.ea_sync[1]; // [R5]
      end else begin
        next_state.mc_cnt = state.mc_cnt + 4'h1;
      end
    end

    // write channels captured in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_state.aw_full = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_state.w_full = 1'b1;
      next_state.w_data = s_axi_wdata[7:0];
      next_state.w_lane = s_axi_wstrb[0];
    end

    // write performed once both halves are held
    if (state.aw_full && state.w_full) begin
      next_state.aw_full = 1'b0;
      next_state.w_full  = 1'b0;
      next_state.b_valid = 1'b1;
      next_state.b_resp  = mccs_pkg::RESP_OKAY;
      case (state.aw_addr)
        mccs_pkg::ADDR_CLOCK_OPTION: begin
          if (state.w_lane) begin
            next_state.div_en  = state.w_data[mccs_pkg::DIV_ENABLE_POS];            // [R8]
            next_state.div_sel = state.w_data[mccs_pkg::DIV_SELECT_LSB +: 2];      // [R9]
          end
        end
        mccs_pkg::ADDR_IAP_COMMAND: begin
          if (state.w_lane && state.w_data == mccs_pkg::IAP_CLOCK_DOUBLE) begin
            next_state.iap_dbl = 1'b1; // [R3]
          end
        end
        mccs_pkg::ADDR_FLASH_STATUS: begin
          // status is read only, writes are ignored
        end
        default: begin
          next_state.b_resp = mccs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (state.b_valid && s_axi_bready) begin
      next_state.b_valid = 1'b0;
    end

    // read answered the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      next_state.r_valid = 1'b1;
      next_state.r_resp  = mccs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        mccs_pkg::ADDR_CLOCK_OPTION: begin
          rd[mccs_pkg::DIV_ENABLE_POS]      = state.div_en;
          rd[mccs_pkg::DIV_SELECT_LSB +: 2] = state.div_sel;
        end
        mccs_pkg::ADDR_FLASH_STATUS: begin
          rd[mccs_pkg::STATUS_DOUBLE_POS] = state.dbl_act; // [R4]
          rd[mccs_pkg::STATUS_EXT_POS]    = state.ea_sync[1];
        end
        mccs_pkg::ADDR_IAP_COMMAND: begin
          // command register reads zero
        end
        default: begin
          next_state.r_resp = mccs_pkg::RESP_SLVERR;
        end
      endcase
      next_state.r_data = rd;
    end else if (state.r_valid && s_axi_rready) begin
      next_state.r_valid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register, frozen while the clock enable is low
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state         <= '0;
      state.div_en  <= mccs_pkg::RESET_DIV_ENABLE; // [R11]
      state.div_sel <= mccs_pkg::RESET_DIV_SELECT; // [R11]
      state.act_en  <= mccs_pkg::RESET_DIV_ENABLE; // [R11]
      state.act_sel <= mccs_pkg::RESET_DIV_SELECT;
    end else if (clk_en_i) begin
      state <= next_state;
    end
  end

endmodule : mccs_top

// ---- testbench/mccs_checker.sv ----
/* checker for the clock scaler: watches the top module ports only.
   assumes one clock domain and an active high asynchronous reset. */
module mccs_checker (
  // clock, reset and freeze
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        clk_en_i,
  // clock products
  input wire logic        osc_output_pin_o,
  input wire logic        sys_clk_tick_o,
  input wire logic        machine_cycle_o,
  input wire logic        double_speed_o,
  // register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // register bus responses
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------
  // helper: ticks since the last machine cycle
  // ----------------------------------------
  logic [4:0] tick_cnt;  // saturates far above 12
  logic       seen_mc;   // first cycle after reset has no start mark
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt <= 5'h00;
      seen_mc  <= 1'b0;
    end else if (clk_en_i && machine_cycle_o) begin
      // outputs stand through frozen edges, so count each value once
      tick_cnt <= 5'h00;
      seen_mc  <= 1'b1;
    end else if (clk_en_i && sys_clk_tick_o && tick_cnt != 5'h1f) begin
      tick_cnt <= tick_cnt + 5'h01;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // the release edge itself is still a reset edge for the design
  property p_osc_toggle;
    clk_en_i && !reset_i |=> osc_output_pin_o != $past(osc_output_pin_o);
  endproperty
  a_osc_toggle: assert property (p_osc_toggle) else $error("osc pin missed a toggle");
  property p_mc_len;
    clk_en_i && seen_mc && machine_cycle_o
      |-> (tick_cnt + 5'(sys_clk_tick_o)) inside {5'h06, 5'h0c};
  endproperty
  a_mc_len: assert property (p_mc_len) else $error("machine cycle length wrong");
  property p_ds_edge; $changed(double_speed_o) |-> machine_cycle_o || $past(machine_cycle_o);
  endproperty
  a_ds_edge: assert property (p_ds_edge) else $error("speed change off boundary");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_w_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en_i ##1 clk_en_i
      |=> s_axi_bvalid;
  endproperty
  a_w_lat: assert property (p_w_lat) else $error("write response late");
  property p_r_lat; s_axi_arvalid && s_axi_arready && clk_en_i |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read response late");
endmodule : mccs_checker

bind mccs_top mccs_checker chk_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
  .osc_output_pin_o(osc_output_pin_o), .sys_clk_tick_o(sys_clk_tick_o),
  .machine_cycle_o(machine_cycle_o), .double_speed_o(double_speed_o),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata));

// ---- testbench/mccs_osc_model.sv ----
/* oscillator model: turns the bench clock into oscillator clock enables.
   assumes slow_i is driven off the sampling edge; slow mode gates half the edges. */
module mccs_osc_model (
  input  wire logic clk_sys_i,  // bench clock
  input  wire logic slow_i,     // high: a slow crystal, one edge in two
  output logic      clk_en_o    // oscillator clock enable to the block
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phase = 1'b0;  // free running, so slow mode never stops the oscillator
  always @(posedge clk_sys_i) phase <= ~phase;
  assign clk_en_o = ~slow_i | phase;
endmodule : mccs_osc_model

// ---- testbench/mccs_bench.sv ----
/* bench for the clock scaler: register bus tasks, one task per scenario.
   assumes the oscillator model and the bound checker are compiled alongside. */
module mccs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, reset_i = 1, slow = 0, host = 0, ext = 0, clk_en_i;
  logic osc_o, tick_o, mc_o, ds_o, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] awaddr = 0, wstrb = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  int err_total = 0, checked = 0, cyc = 0, n;
  int ratio [4] = '{4, 16, 256, 1024};
  always #2 clk_sys_i = ~clk_sys_i;
  // hang guard well above the expected run length
  always @(posedge clk_sys_i) if (++cyc == 60000) begin err_total++; end_of_test(); end
  mccs_osc_model osc (.clk_sys_i(clk_sys_i), .slow_i(slow), .clk_en_o(clk_en_i));
  mccs_top DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .host_double_speed_i(host), .external_access_pin_i(ext), .osc_output_pin_o(osc_o),
    .sys_clk_tick_o(tick_o), .machine_cycle_o(mc_o), .double_speed_o(ds_o),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ---------------- shared tasks ----------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin err_total++; $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e); end
  endtask : chk
  task do_reset; reset_i <= 1; repeat (6) @(posedge clk_sys_i); reset_i <= 0; endtask : do_reset
  // handshakes judged at the falling edge, so inputs are already stable for the next rise
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ah, wh, bh;
    @(posedge clk_sys_i);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1; bh = 0;
    while (!bh) begin
      @(negedge clk_sys_i); ah = awvalid & awready; wh = wvalid & wready; bh = bvalid; resp = bresp;
      @(posedge clk_sys_i); if (ah) awvalid <= 0; if (wh) wvalid <= 0;
    end
    bready <= 0;
  endtask : wr
  task rdw(input logic [3:0] a);
    logic ah, rh;
    @(posedge clk_sys_i); araddr <= a; arvalid <= 1; rready <= 1; rh = 0;
    while (!rh) begin
      @(negedge clk_sys_i); ah = arvalid & arready; rh = rvalid;
      if (rh) begin rd = rdata; resp = rresp; end
      @(posedge clk_sys_i); if (ah) arvalid <= 0;
    end
    rready <= 0;
  endtask : rdw
  // cycles between two pulses of the tick (m=0) or machine cycle (m=1)
  task gap(input bit m);
    n = 0;
    do @(negedge clk_sys_i); while (!(m ? mc_o : tick_o));
    do begin @(negedge clk_sys_i); n++; end while (!(m ? mc_o : tick_o));
  endtask : gap
  // ---------------- scenarios ----------------
  task t_reset;
    rdw(4'h0); chk(rd, 32'h0);
    rdw(4'h4); chk(rd, 32'h0);
    gap(1); chk(n, 12);
    gap(0); chk(n, 1);
  endtask : t_reset
  task t_div;
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 32'(i * 2 + 1), 4'hf); gap(0); gap(0); chk(n, ratio[i]);
    end
    wr(4'h0, 32'h6, 4'hf); gap(0); gap(0); chk(n, 1);
    wr(4'h0, 32'h7, 4'h0); gap(0); chk(n, 1);
    wr(4'hc, 32'h1, 4'hf); chk(resp, 2'h2);
    rdw(4'hc); chk(resp, 2'h2);
    rdw(4'h0); chk(rd, 32'h6);
  endtask : t_div
  task t_double;
    logic prev_osc;
    ext <= 1; wr(4'h8, 32'h0c, 4'hf); repeat (40) @(posedge clk_sys_i);
    gap(1); chk(n, 12);
    rdw(4'h4); chk(rd, 32'h01);
    wr(4'h8, 32'h0d, 4'hf); repeat (40) @(posedge clk_sys_i);
    rdw(4'h4); chk(rd, 32'h81);
    gap(1); chk(n, 6);
    prev_osc = osc_o; @(negedge clk_sys_i); chk(osc_o, !prev_osc);
    @(posedge clk_sys_i); slow <= 1; repeat (60) @(posedge clk_sys_i); slow <= 0;
    ext <= 0; repeat (40) @(posedge clk_sys_i);
    gap(1); chk(n, 12);
    rdw(4'h4); chk(rd, 32'h0);
  endtask : t_double
  task t_host;
    do_reset(); rdw(4'h0); chk(rd, 32'h0);
    @(negedge clk_sys_i); chk(ds_o, 1'b0);
    @(posedge clk_sys_i); host <= 1; ext <= 1; repeat (40) @(posedge clk_sys_i);
    @(negedge clk_sys_i); chk(ds_o, 1'b1);
    gap(1); chk(n, 6);
  endtask : t_host
  task end_of_test;
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    do_reset(); t_reset(); t_div(); t_double(); t_host(); end_of_test();
  end
endmodule : mccs_bench
